// ### logic/bcm_map.svh
/*
  Constants of the bus-cycle break matcher: field positions of the
  condition byte, group codes, reset values and trigger widths.
  Assumes it is included by bare name from the package.
*/
`ifndef BCM_MAP_SVH
`define BCM_MAP_SVH

// ----------------------------------------------------------------------
// Condition byte layout.
// ----------------------------------------------------------------------
`define BCM_INIT_HI   7
`define BCM_INIT_LO   6
`define BCM_TYPE_HI   5
`define BCM_TYPE_LO   4
`define BCM_DIR_HI    3
`define BCM_DIR_LO    2
`define BCM_SIZE_HI   1
`define BCM_SIZE_LO   0

// ----------------------------------------------------------------------
// Group codes, reset values and request level.
// ----------------------------------------------------------------------
`define BCM_GRP_NONE  2'h0
`define BCM_GRP_A     2'h1
`define BCM_GRP_B     2'h2
`define BCM_GRP_BOTH  2'h3
`define BCM_SIZE_ANY  2'h0
`define BCM_SIZE_BYTE 2'h1
`define BCM_SIZE_WORD 2'h2
`define BCM_SIZE_LONG 2'h3
`define BCM_ADDR_RST  16'h0000
`define BCM_COND_RST  8'h00
`define BCM_CTRL_RST  3'h0
`define BCM_IRQ_LEVEL 4'hF

// ----------------------------------------------------------------------
// Trigger low widths in clock periods, minus one.
// ----------------------------------------------------------------------
`define BCM_TW_1      5'h00
`define BCM_TW_4      5'h03
`define BCM_TW_8      5'h07
`define BCM_TW_16     5'h0F

`endif

// ### logic/bcm_pkg.sv
/*
  Types of the bus-cycle break matcher.
  Assumes bcm_map.svh is on the include path.
*/
package bcm_pkg;
  `include "bcm_map.svh"

  // Two-bit group of the condition byte.
  typedef logic [1:0] bcm_grp_t;

  // Access size reported by the monitored bus.
  typedef enum logic [1:0] {
    BCM_SZ_NONE,
    BCM_SZ_BYTE,
    BCM_SZ_WORD,
    BCM_SZ_LONG
  } bcm_size_t;
endpackage

// ### logic/bcm_break_matcher.sv
/*
  Bus-cycle break matcher: compares each CPU or DMA internal bus cycle
  with a programmed address and cycle condition, requests a break
  interrupt and drives an active-low trigger pulse.
  Assumes the bus monitor inputs are synchronous to ref_clk and that the
  CPU flags overrun and branch-destination fetches as it issues them.
  // Behaviour
  // - Address is high half over low half.
  // - Condition byte: initiator, type, direction, size groups.
  // - Fetch break raised before matched instruction executes.
  // - Fetch with write direction never matches.
  // - Fetch condition on odd address never matches.
  // - Odd branch-target fetch breaks after address error.
  // - CPU word data write matches exact address.
  // - Word data condition on odd address never matches.
  // - DMA longword data read matches programmed address.
  // - DMA with instruction fetch never matches.
  // - Second of paired fetch breaks despite condition change.
  // - Overrun fetches give no fetch break.
  // - Overrun fetch satisfies enabled data condition, breaks.
  // - Higher-priority exception may drop pending break.
  // - No break on first non-delay branch target fetch.
  // - New match restarts trigger width, stays low.
  // - Overrun fetch match pulses trigger, no interrupt.
  // - Data and DMA matches trigger like interrupt.
  // - Interrupt disable keeps trigger, suppresses request.
  // - Standby after reset: no match, no settings.
  // - Width codes give 1, 4, 8, 16 clocks.
  // - Any 00 initiator/type/direction group blocks matching.
  // - Request is level 15, pending while masked.
*/
`timescale 1ns/1ps

module bcm_break_matcher (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // Module standby control, 1 releases standby.
  input  wire logic              standbyRelease,
  // Condition settings, loaded on cfgWrite.
  input  wire logic              cfgWrite,
  input  wire logic [15:0]       breakAddressHighIn,
  input  wire logic [15:0]       breakAddressLowIn,
  input  wire logic [7:0]        breakCycleConditionIn,
  input  wire logic [1:0]        triggerWidthSelIn,
  input  wire logic              breakIrqDisableIn,
  // Monitored bus cycle.
  input  wire logic              busValid,
  input  wire logic [31:0]       busAddr,
  input  wire logic              busDma,
  input  wire logic              busFetch,
  input  wire logic              busWrite,
  input  bcm_pkg::bcm_size_t     busSize,
  input  wire logic              busPairFetch,
  input  wire logic              busOverrun,
  input  wire logic              busBranchTarget,
  input  wire logic              busAddrError,
  // CPU sequencing events.
  input  wire logic              secondIssue,
  input  wire logic              addrErrDone,
  input  wire logic              hiExcAccept,
  // Interrupt controller side.
  input  wire logic              irqAck,
  output logic                   breakIrqReq,
  output logic [3:0]             breakIrqLevel,
  // Status and pin.
  output logic                   matchPulse,
  output logic                   matchTriggerOutN,
  output logic [31:0]            breakAddress,
  output logic [7:0]             breakCycleCondition,
  output logic [2:0]             breakControl
);
  import bcm_pkg::*;

  // All checks below run on the one clock and stand down in reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------------
  // Condition registers.
  // ----------------------------------------------------------------------
  logic [15:0] addrHi_q, addrHi_d, addrLo_q, addrLo_d;
  logic [7:0]  cond_q, cond_d;
  logic [2:0]  ctrl_q, ctrl_d;

  // Standby clears the settings and refuses writes to them.
  always_comb begin
    addrHi_d = addrHi_q;
    addrLo_d = addrLo_q;
    cond_d   = cond_q;
    ctrl_d   = ctrl_q;
    if (!standbyRelease) begin
      addrHi_d = `BCM_ADDR_RST;
      addrLo_d = `BCM_ADDR_RST;
      cond_d   = `BCM_COND_RST;
      ctrl_d   = `BCM_CTRL_RST;
    end else if (cfgWrite) begin
      addrHi_d = breakAddressHighIn;
      addrLo_d = breakAddressLowIn;
      cond_d   = breakCycleConditionIn;
      ctrl_d   = {triggerWidthSelIn, breakIrqDisableIn};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addrHi_q <= `BCM_ADDR_RST;
      addrLo_q <= `BCM_ADDR_RST;
      cond_q   <= `BCM_COND_RST;
      ctrl_q   <= `BCM_CTRL_RST;
    end else begin
      addrHi_q <= addrHi_d;
      addrLo_q <= addrLo_d;
      cond_q   <= cond_d;
      ctrl_q   <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle comparison.
  // ----------------------------------------------------------------------
  logic [31:0] brkAddr, secondAddr;
  bcm_grp_t    gInit, gType, gDir, gSize;
  logic        grpsSet, initOk, dirOk, sizeOk, typeFetch, typeData;
  logic        oddBlock, hitFirst, hitSecond, anyHit;
  logic        fetchHit, dataHit, irqEvent, trigEvent, errHold;

  assign brkAddr    = {addrHi_q, addrLo_q};
  assign secondAddr = busAddr + 32'h0000_0002;
  assign gInit = cond_q[`BCM_INIT_HI:`BCM_INIT_LO];
  assign gType = cond_q[`BCM_TYPE_HI:`BCM_TYPE_LO];
  assign gDir  = cond_q[`BCM_DIR_HI:`BCM_DIR_LO];
  assign gSize = cond_q[`BCM_SIZE_HI:`BCM_SIZE_LO];

  // An initiator, type or direction group left at 00 blocks every new match.
  assign grpsSet = (gInit != `BCM_GRP_NONE) &&
                   (gType != `BCM_GRP_NONE) &&
                   (gDir  != `BCM_GRP_NONE);
  assign initOk  = busDma ? gInit[1] : gInit[0];
  assign dirOk   = busWrite ? gDir[1] : gDir[0];
  assign sizeOk  = (gSize == `BCM_SIZE_ANY) ||
                   (gSize == 2'(busSize));
  // DMA never fetches, and a fetch is never a write.
  assign typeFetch = gType[0] && busFetch && !busDma &&
                     !busWrite;
  assign typeData  = gType[1] && (!busFetch || busOverrun);
  // Fetches and word or longword accesses are even, so an odd
  // condition address can only be met by byte data or an address error.
  assign oddBlock = brkAddr[0] &&
                    (busFetch || gSize[1]);
  assign hitFirst  = (busAddr == brkAddr) && !oddBlock;
  assign hitSecond = busFetch && busPairFetch &&
                     (secondAddr == brkAddr) && !oddBlock;
  // Same-cycle evaluation of every enabled group.
  assign anyHit = standbyRelease && busValid && grpsSet &&
                  initOk && dirOk && sizeOk &&
                  (hitFirst || hitSecond);
  assign fetchHit = anyHit && typeFetch;
  assign dataHit  = anyHit && typeData;
  // Fetch breaks only for fetches that will execute.
  assign irqEvent = dataHit ||
                    (fetchHit && hitFirst && !busOverrun &&
                     !busBranchTarget);
  assign trigEvent = fetchHit || dataHit;
  // An odd branch target fetch waits for the address error handling.
  assign errHold = standbyRelease && busValid && busFetch &&
                   busAddrError && grpsSet && gType[0] && !busDma &&
                   initOk && dirOk && sizeOk &&
                   (busAddr == brkAddr) && brkAddr[0];

  // ----------------------------------------------------------------------
  // Break request and deferred breaks.
  // ----------------------------------------------------------------------
  logic irq_q, irq_d, second_q, second_d, err_q, err_d, match_q, match_d;
  logic raise;

  assign raise = (irqEvent && !busAddrError) ||
                 (second_q && secondIssue) ||
                 (err_q && addrErrDone);

  always_comb begin
    second_d = second_q;
    err_d    = err_q;
    irq_d    = irq_q;
    match_d  = anyHit && (irqEvent || trigEvent);
    // The second instruction's hit is captured at fetch time, so a
    // later rewrite of the condition cannot cancel it.
    if (secondIssue)
      second_d = 1'b0;
    if (fetchHit && hitSecond && !busOverrun && !busBranchTarget)
      second_d = 1'b1;
    if (addrErrDone)
      err_d = 1'b0;
    if (errHold)
      err_d = 1'b1;
    // Held until the controller takes it, a higher-priority exception is accepted or standby is entered; while masked it stays pending.
    if (irqAck || hiExcAccept)
      irq_d = 1'b0;
    if (hiExcAccept) begin
      second_d = 1'b0;
      err_d    = 1'b0;
    end
    if (raise && !ctrl_q[0])
      irq_d = 1'b1;
    if (!standbyRelease) begin
      irq_d    = 1'b0;
      second_d = 1'b0;
      err_d    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_q    <= 1'b0;
      second_q <= 1'b0;
      err_q    <= 1'b0;
      match_q  <= 1'b0;
    end else begin
      irq_q    <= irq_d;
      second_q <= second_d;
      err_q    <= err_d;
      match_q  <= match_d;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger pulse.
  // ----------------------------------------------------------------------
  logic       trigOn_q, trigOn_d;
  logic [4:0] trigCnt_q, trigCnt_d, width;

  always_comb begin
    unique case (ctrl_q[2:1])
      2'h0: width = `BCM_TW_1;
      2'h1: width = `BCM_TW_4;
      2'h2: width = `BCM_TW_8;
      2'h3: width = `BCM_TW_16;
    endcase
  end

  // A fresh match reloads the count, so back-to-back hits stretch it.
  always_comb begin
    trigOn_d  = trigOn_q;
    trigCnt_d = trigCnt_q;
    if (trigEvent) begin
      trigOn_d  = 1'b1;
      trigCnt_d = width;
    end else if (trigOn_q) begin
      if (trigCnt_q == 5'h00)
        trigOn_d = 1'b0;
      else
        trigCnt_d = trigCnt_q - 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      trigOn_q  <= 1'b0;
      trigCnt_q <= 5'h00;
    end else begin
      trigOn_q  <= trigOn_d;
      trigCnt_q <= trigCnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign breakIrqReq         = irq_q;
  assign breakIrqLevel       = `BCM_IRQ_LEVEL;
  assign matchPulse          = match_q;
  assign matchTriggerOutN    = !trigOn_q;
  assign breakAddress        = brkAddr;
  assign breakCycleCondition = cond_q;
  assign breakControl        = ctrl_q;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  sequence s_trig_hit;
    trigEvent && ctrl_q[2:1] == 2'h2;
  endsequence
  // Still low on the eighth clock after the hit, high on the ninth.
  sequence s_low_then_high;
    !matchTriggerOutN ##1 matchTriggerOutN;
  endsequence

  a_width_eight: assert property (
    s_trig_hit ##1 !trigEvent [*8] |-> s_low_then_high)
    else $error("Eight-clock trigger width wrong.");
  a_restart_low: assert property (
    trigEvent |=> !matchTriggerOutN)
    else $error("Trigger not low after match.");
  a_standby_quiet: assert property (
    !standbyRelease |=> !breakIrqReq && !matchPulse && cond_q == 8'h00)
    else $error("Activity during standby.");
  a_null_group: assert property (
    gDir == 2'h0 |=> !$past(trigEvent) && !matchPulse)
    else $error("Match with empty group.");
  a_irq_disable: assert property (
    ctrl_q[0] && !irq_q |=> !breakIrqReq)
    else $error("Request raised while disabled.");
  a_overrun_noirq: assert property (
    busValid && busOverrun && gType == 2'h1 && !irq_q &&
      !second_q && !err_q |=> !breakIrqReq)
    else $error("Overrun fetch raised request.");
  a_dma_fetch: assert property (
    busValid && busDma && busFetch && gType == 2'h1 |-> !trigEvent)
    else $error("DMA fetch matched.");
  a_match_single: assert property (
    matchPulse && !$past(anyHit, 1) |-> 1'b0)
    else $error("Match indication without cause.");
  a_pending_held: assert property (
    breakIrqReq && !irqAck && !hiExcAccept && standbyRelease
      |=> breakIrqReq)
    else $error("Pending request dropped.");
  a_fetch_write: assert property (
    busFetch && gType == 2'h1 && gDir == 2'h2 |-> !trigEvent)
    else $error("Fetch matched write condition.");
endmodule

// ### sim/bcm_irq_ctrl_model.sv
/*
  Interrupt controller model facing the break request: it takes the
  request after a chosen delay, or leaves it pending while masked.
  Assumes the request is a level synchronous to ref_clk.
*/
`timescale 1ns/1ps

module bcm_irq_ctrl_model (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Request from the break matcher.
  input  wire logic       breakIrqReq,
  input  wire logic [3:0] breakIrqLevel,
  // Processor mask level and answer speed.
  input  wire logic [3:0] maskLevel,
  input  wire logic [3:0] ackDelay,
  output logic            irqAck
);
  logic [3:0] waitQ;

  // A request above the mask waits ackDelay clocks and is then taken
  // with a one-clock acknowledge; a masked one simply stays pending.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      waitQ  <= 4'h0;
      irqAck <= 1'h0;
    end else if (breakIrqReq && !irqAck && breakIrqLevel > maskLevel) begin
      waitQ  <= waitQ + 4'h1;
      irqAck <= (waitQ >= ackDelay);
    end else begin
      waitQ  <= 4'h0;
      irqAck <= 1'h0;
    end
  end
endmodule

// ### sim/test_bcm_break_matcher.sv
/*
  Self-checking bench of the break matcher: settings and bus cycles as
  port sequences, interrupt controller model on the request.
  Assumes logic/ is on the include path and the package compiles first.
*/
`timescale 1ns/1ps

module test_bcm_break_matcher;
  import bcm_pkg::*;
  logic        ref_clk = 1'h0;
  logic        resetn, stby, cfgWrite, irqDis, busValid, busDma, busFetch;
  logic        busWrite, pairF, ovr, brT, aErr, secIss, aeDone, hiExc;
  logic        irqAck, irqReq, mPulse, trigN;
  logic [15:0] addrHi, addrLo;
  logic [7:0]  cond, rbCond;
  logic [1:0]  widthSel;
  logic [31:0] busAddr, rbAddr;
  logic [3:0]  irqLvl, maskLevel, ackDelay;
  logic [2:0]  rbCtrl;
  bcm_size_t   busSize;
  int          mismatches, comparisons;
  int          w[4] = '{1, 4, 8, 16};

  bcm_break_matcher DUT (
    .ref_clk(ref_clk), .resetn(resetn), .standbyRelease(stby),
    .cfgWrite(cfgWrite), .breakAddressHighIn(addrHi),
    .breakAddressLowIn(addrLo), .breakCycleConditionIn(cond),
    .triggerWidthSelIn(widthSel), .breakIrqDisableIn(irqDis),
    .busValid(busValid), .busAddr(busAddr), .busDma(busDma),
    .busFetch(busFetch), .busWrite(busWrite), .busSize(busSize),
    .busPairFetch(pairF), .busOverrun(ovr), .busBranchTarget(brT),
    .busAddrError(aErr), .secondIssue(secIss), .addrErrDone(aeDone),
    .hiExcAccept(hiExc), .irqAck(irqAck), .breakIrqReq(irqReq),
    .breakIrqLevel(irqLvl), .matchPulse(mPulse),
    .matchTriggerOutN(trigN), .breakAddress(rbAddr),
    .breakCycleCondition(rbCond), .breakControl(rbCtrl));

  bcm_irq_ctrl_model ctrlModel (
    .ref_clk(ref_clk), .resetn(resetn), .breakIrqReq(irqReq),
    .breakIrqLevel(irqLvl), .maskLevel(maskLevel),
    .ackDelay(ackDelay), .irqAck(irqAck));

  // Free-running 50 MHz clock.
  always #10 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Access tasks.
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Inputs always move 1 ns after the rising edge.
  task automatic cyc(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic cfg(logic [31:0] a, logic [7:0] c, logic [2:0] k);
    {addrHi, addrLo} = a;
    cond = c;
    {widthSel, irqDis} = k;
    cfgWrite = 1'h1;
    cyc();
    cfgWrite = 1'h0;
    chk("address", a, rbAddr);
    chk("condition", c, rbCond);
    chk("control", k, rbCtrl);
  endtask

  // One bus cycle; f is {dma, fetch, write, overrun}. Side flags set
  // by the caller last for this cycle only.
  task automatic hit(logic [31:0] a, logic [3:0] f, bcm_size_t s);
    busAddr = a;
    {busDma, busFetch, busWrite, ovr} = f;
    busSize = s;
    busValid = 1'h1;
    cyc();
    {busValid, busDma, busFetch, busWrite, ovr, brT, pairF, aErr} = '0;
  endtask

  // Unmasking lets the controller model take the request.
  task automatic clr();
    maskLevel = 4'h0;
    cyc(8);
    chk("request taken", 0, irqReq);
    maskLevel = 4'hF;
  endtask

  task automatic run(logic [31:0] a, logic [7:0] c, logic [31:0] ba,
                     logic [3:0] f, bcm_size_t s, logic m, logic r,
                     logic [2:0] k = 3'h0);
    int n;
    cfg(a, c, k);
    hit(ba, f, s);
    chk("pulse", m, mPulse);
    chk("request", r, irqReq);
    n = 0;
    while (trigN === 1'h0 && n < 40) begin
      n++;
      cyc();
    end
    chk("trigger width", m ? w[k[2:1]] : 0, n);
    chk("pending", r, irqReq);
    clr();
  endtask

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred clocks the tests need.
  initial begin
    #400000;
    mismatches++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    {resetn, stby, cfgWrite, irqDis, widthSel, cond} = '0;
    {addrHi, addrLo, busAddr, busSize} = '0;
    {busValid, busDma, busFetch, busWrite, pairF, ovr, brT, aErr} = '0;
    {secIss, aeDone, hiExc, mismatches, comparisons} = '0;
    maskLevel = 4'hF;
    ackDelay = 4'h3;
    repeat (8) @(posedge ref_clk);
    #1;
    resetn = 1'h1;
    chk("idle trigger", 1, trigN);
    chk("level", 4'hF, irqLvl);
    {addrHi, addrLo, cond} = {32'h00000404, 8'h54};
    cfgWrite = 1'h1;
    cyc();
    cfgWrite = 1'h0;
    hit(32'h00000404, 4'h4, BCM_SZ_WORD);
    chk("standby write", 0, rbAddr);
    chk("standby match", 0, mPulse);
    stby = 1'h1;
    cyc();
    run(32'h404, 8'h54, 32'h404, 4'h4, BCM_SZ_WORD, 1, 1);
    run(32'h404, 8'h54, 32'h406, 4'h4, BCM_SZ_WORD, 0, 0);
    run(32'h15389C, 8'h58, 32'h15389C, 4'h4, BCM_SZ_WORD, 0, 0);
    run(32'h30147, 8'h54, 32'h30147, 4'h4, BCM_SZ_WORD, 0, 0);
    run(32'h123456, 8'h6A, 32'h123456, 4'h2, BCM_SZ_WORD, 1, 1);
    run(32'h123456, 8'h6A, 32'h123456, 4'h0, BCM_SZ_WORD, 0, 0);
    run(32'h123456, 8'h6A, 32'h123456, 4'h2, BCM_SZ_LONG, 0, 0);
    run(32'hA80391, 8'h66, 32'hA80391, 4'h0, BCM_SZ_WORD, 0, 0);
    run(32'hA80391, 8'h65, 32'hA80391, 4'h0, BCM_SZ_BYTE, 1, 1);
    run(32'h76BCDC, 8'hA7, 32'h76BCDC, 4'h8, BCM_SZ_LONG, 1, 1);
    run(32'h76BCDC, 8'hA7, 32'h76BCDC, 4'h0, BCM_SZ_LONG, 0, 0);
    run(32'h2345C8, 8'h94, 32'h2345C8, 4'hC, BCM_SZ_WORD, 0, 0);
    run(32'h44, 8'h54, 32'h44, 4'h5, BCM_SZ_WORD, 1, 0);
    run(32'h404, 8'h74, 32'h404, 4'h5, BCM_SZ_WORD, 1, 1);
    run(32'h404, 8'h14, 32'h404, 4'h4, BCM_SZ_WORD, 0, 0);
    run(32'h404, 8'h44, 32'h404, 4'h4, BCM_SZ_WORD, 0, 0);
    run(32'h404, 8'h50, 32'h404, 4'h4, BCM_SZ_WORD, 0, 0);
    brT = 1'h1;
    run(32'h404, 8'h54, 32'h404, 4'h4, BCM_SZ_WORD, 1, 0);
    // Every width code with the request disabled.
    run(32'h456, 8'h6A, 32'h456, 4'h2, BCM_SZ_WORD, 1, 0, 3'h1);
    run(32'h456, 8'h6A, 32'h456, 4'h2, BCM_SZ_WORD, 1, 0, 3'h3);
    run(32'h456, 8'h6A, 32'h456, 4'h2, BCM_SZ_WORD, 1, 0, 3'h5);
    run(32'h456, 8'h6A, 32'h456, 4'h2, BCM_SZ_WORD, 1, 0, 3'h7);
    // A second hit two clocks in restarts the four-clock trigger.
    cfg(32'h00123456, 8'h6A, 3'h3);
    hit(32'h00123456, 4'h2, BCM_SZ_WORD);
    cyc();
    chk("trigger held", 0, trigN);
    hit(32'h00123456, 4'h2, BCM_SZ_WORD);
    cyc(3);
    chk("trigger restarted", 0, trigN);
    cyc();
    chk("trigger released", 1, trigN);
    // Odd branch target waits for the address error handling.
    ackDelay = 4'h0;
    cfg(32'h00030147, 8'h54, 0);
    aErr = 1'h1;
    hit(32'h00030147, 4'h4, BCM_SZ_WORD);
    chk("odd target early", 0, irqReq);
    aeDone = 1'h1;
    cyc();
    aeDone = 1'h0;
    chk("odd target", 1, irqReq);
    clr();
    // Second of a fetched pair breaks though the condition moved on.
    cfg(32'h00000406, 8'h54, 0);
    pairF = 1'h1;
    hit(32'h00000404, 4'h4, BCM_SZ_WORD);
    chk("pair early", 0, irqReq);
    cfg(32'h00001000, 8'h54, 0);
    secIss = 1'h1;
    cyc();
    secIss = 1'h0;
    chk("pair second", 1, irqReq);
    clr();
    // A higher-priority exception drops the pending break; the
    // condition sits on a plain fetch, not a branch destination.
    cfg(32'h00000404, 8'h54, 0);
    hit(32'h00000404, 4'h4, BCM_SZ_WORD);
    hiExc = 1'h1;
    cyc();
    hiExc = 1'h0;
    chk("dropped", 0, irqReq);
    // Standby clears settings and stops matching.
    stby = 1'h0;
    cyc();
    chk("standby clear", 0, rbAddr);
    hit(32'h00000404, 4'h4, BCM_SZ_WORD);
    chk("standby idle", 0, mPulse);
    summarize();
  end
endmodule
